/* logic/cpu_addr_map_regs.svh */
`ifndef CPU_ADDR_MAP_REGS_SVH
`define CPU_ADDR_MAP_REGS_SVH

// ----------------------------------------
// Physical map boundaries (26-bit)
// ----------------------------------------
`define ROM_WIN_END 26'h00FFFFF
`define EXT_BASE 26'h0100000
`define EXT_END 26'h0FFFFFF
`define UNUSABLE_END 26'h3FEFFFF
`define RAM_WIN_BASE 26'h3FF0000
`define PER_BASE 26'h3FFF000

// ----------------------------------------
// Implemented sizes and reset values
// ----------------------------------------
`define ROM_SIZE_KB_DEF 640
`define RAM_SIZE_KB_DEF 48
`define PC_RESET 32'h00000000
`define PREFETCH_STEP 26'h0000004

// ----------------------------------------
// Timing
// ----------------------------------------
`define MODE_CAPTURE_CYCLES 2'h2

`endif

/* logic/cpu_addr_map_pkg.sv */
package cpu_addr_map_pkg;
	typedef enum logic [2:0] {
		TGT_NONE = 3'b000,
		TGT_ROM = 3'b001,
		TGT_RAM = 3'b010,
		TGT_PER = 3'b011,
		TGT_EXT = 3'b100,
		TGT_ERR = 3'b101
	} target_e;
	typedef enum logic [1:0] {
		MODE_UNSET = 2'b00,
		MODE_NORMAL = 2'b01,
		MODE_FLASHPROG = 2'b10,
		MODE_PROHIBITED = 2'b11
	} mode_e;
	typedef enum logic [1:0] {
		SIZE_BYTE = 2'b00,
		SIZE_HALF = 2'b01,
		SIZE_WORD = 2'b10
	} size_e;
	typedef enum logic [1:0] {
		SPLIT_IDLE = 2'b00,
		SPLIT_LOW = 2'b01,
		SPLIT_HIGH = 2'b10
	} split_e;
endpackage : cpu_addr_map_pkg

/* logic/periph_access_splitter.sv */
`timescale 1ns/100ps
module periph_access_splitter (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic start,
	input wire logic [11:0] addr,
	input wire cpu_addr_map_pkg::size_e size,
	input wire logic isWrite,
	input wire logic [31:0] wdata,
	input wire logic byteWide,
	input wire logic [15:0] perRdata,
	output logic perStrobe,
	output logic [11:0] perAddr,
	output logic perWe,
	output logic [1:0] perByteEn,
	output logic [15:0] perWdata,
	output logic busy,
	output logic done,
	output logic [31:0] rdata
);
	import cpu_addr_map_pkg::*;

	split_e state_reg, state_next;
	logic [11:0] addr_reg;
	size_e size_reg;
	logic we_reg;
	logic [31:0] wdata_reg;
	logic [31:0] rdata_reg;
	logic done_reg;
	logic [11:0] addrAligned;
	logic lastHalf;

	// ----------------------------------------
	// Sequencing
	// ----------------------------------------
	assign addrAligned = (size == SIZE_WORD) ? {addr[11:2], 2'b00} :
		(size == SIZE_HALF) ? {addr[11:1], 1'b0} : addr;
	assign lastHalf = (state_reg == SPLIT_HIGH) || (state_reg == SPLIT_LOW && size_reg != SIZE_WORD);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			SPLIT_IDLE: if (start) state_next = SPLIT_LOW;
			SPLIT_LOW: state_next = (size_reg == SIZE_WORD) ? SPLIT_HIGH : SPLIT_IDLE;
			SPLIT_HIGH: state_next = SPLIT_IDLE;
			default: state_next = SPLIT_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_reg <= SPLIT_IDLE;
			addr_reg <= 12'h000;
			size_reg <= SIZE_BYTE;
			we_reg <= 1'b0;
			wdata_reg <= 32'h00000000;
			done_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			done_reg <= lastHalf;
			if (start && state_reg == SPLIT_IDLE) begin
				addr_reg <= addrAligned;
				size_reg <= size;
				we_reg <= isWrite;
				wdata_reg <= wdata;
			end
		end
	end

	// Read halves assembled low then high
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rdata_reg <= 32'h00000000;
		end else if (state_reg == SPLIT_LOW && !we_reg) begin
			if (size_reg == SIZE_BYTE) begin
				rdata_reg <= {24'h000000, addr_reg[0] ? perRdata[15:8] : perRdata[7:0]};
			end else begin
				rdata_reg <= {16'h0000, perRdata};
			end
		end else if (state_reg == SPLIT_HIGH && !we_reg) begin
			rdata_reg[31:16] <= perRdata;
		end
	end

	// ----------------------------------------
	// Peripheral side
	// ----------------------------------------
	assign perStrobe = (state_reg != SPLIT_IDLE);
	assign perAddr = (state_reg == SPLIT_HIGH) ? {addr_reg[11:2], 2'b10} : addr_reg;
	assign perWe = perStrobe && we_reg;
	assign perWdata = (state_reg == SPLIT_HIGH) ? wdata_reg[31:16] :
		(size_reg == SIZE_BYTE) ? {2{wdata_reg[7:0]}} : wdata_reg[15:0];
	// Undefined peripheral offsets are passed through unchecked
	assign perByteEn = (size_reg == SIZE_BYTE) ? (addr_reg[0] ? 2'b10 : 2'b01) :
		(we_reg && byteWide) ? 2'b01 : 2'b11;
	assign busy = perStrobe;
	assign done = done_reg;
	assign rdata = rdata_reg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence seqLowHalf;
		perStrobe && perAddr[1:0] == 2'b00;
	endsequence
	sequence seqHighHalf;
		perStrobe && perAddr[1:0] == 2'b10;
	endsequence

	chk_word_split_order: assert property (@(posedge clk_sys) disable iff (!rstn)
		(start && !busy && size == SIZE_WORD) |-> ##1 seqLowHalf ##1 seqHighHalf ##1 (done && !perStrobe))
		else $error("word access not split low then high");

	chk_byte_reg_write: assert property (@(posedge clk_sys) disable iff (!rstn)
		(perWe && byteWide && size_reg != SIZE_BYTE) |-> perByteEn == 2'b01)
		else $error("halfword write to byte register touched upper byte");
endmodule : periph_access_splitter

/* logic/cpu_address_map_decoder.sv */
`timescale 1ns/100ps
`include "cpu_addr_map_regs.svh"
//Contract
// - Sample both mode pins at reset release; A low normal, A high B low flash.
// - Program counter keeps upper six bits zero; carry out of bit 25 dropped.
// - Instruction addresses wrap: top of program space follows into address zero.
// - Operand addresses ignore bits 31 to 26; 64 images of one space.
// - Operand address sums drop everything beyond 32 bits.
// - Data view sign-extends physical bit 25 into the upper six bits.
// - Lowest megabyte: fetch and read go to ROM, writes go external.
// - ROM up to 1 MB from zero; beyond implemented size is prohibited.
// - RAM ends at 03FFEFFF; below implemented start inside window is prohibited.
// - 03FFF000 to 03FFFFFF is peripheral area; fetch there is refused.
// - 00100000 to 00FFFFFF routes to external memory.
// - 01000000 to 03FEFFFF is unusable; fetch there is refused.
// - Peripheral word access becomes two halfwords, low first, low bits ignored.
// - Halfword to byte register: upper read byte undefined, only low byte written.
// - Prefetch past the top of RAM never reaches the peripheral area.
module cpu_address_map_decoder #(
	parameter int unsigned ROM_SIZE_KB = `ROM_SIZE_KB_DEF,
	parameter int unsigned RAM_SIZE_KB = `RAM_SIZE_KB_DEF
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic modeSelPinA,
	input wire logic modeSelPinB,
	output cpu_addr_map_pkg::mode_e opMode,
	output logic modeValid,
	input wire logic pcLoad,
	input wire logic [31:0] pcLoadAddr,
	input wire logic pcBranch,
	input wire logic [31:0] branchDisp,
	input wire logic pcAdvance,
	input wire logic [2:0] pcStep,
	input wire logic fetchReq,
	output logic [31:0] fetchAddr,
	output cpu_addr_map_pkg::target_e fetchSel,
	output logic fetchErr,
	input wire logic prefetchReq,
	output logic [31:0] prefetchAddr,
	output logic prefetchIssue,
	input wire logic dataReq,
	input wire logic dataWrite,
	input wire cpu_addr_map_pkg::size_e dataSize,
	input wire logic [31:0] opBase,
	input wire logic [31:0] opDisp,
	input wire logic [31:0] dataWdata,
	output logic dataReady,
	output logic [31:0] dataView,
	output cpu_addr_map_pkg::target_e dataSel,
	output logic romStrobe,
	output logic ramStrobe,
	output logic extStrobe,
	output logic memWrite,
	output cpu_addr_map_pkg::size_e memSize,
	output logic [25:0] memAddr,
	output logic [31:0] memWdata,
	input wire logic [31:0] romRdata,
	input wire logic [31:0] ramRdata,
	input wire logic [31:0] extRdata,
	input wire logic perByteWide,
	input wire logic [15:0] perRdata,
	output logic perStrobe,
	output logic [11:0] perAddr,
	output logic perWe,
	output logic [1:0] perByteEn,
	output logic [15:0] perWdata,
	output logic dataRespValid,
	output logic [31:0] dataRdata,
	output logic accessErr
);
	import cpu_addr_map_pkg::*;

	localparam logic [25:0] ROM_LIMIT = 26'(ROM_SIZE_KB * 1024);
	localparam logic [25:0] RAM_START = `PER_BASE - 26'(RAM_SIZE_KB * 1024);

	// ----------------------------------------
	// Region decode
	// ----------------------------------------
	function automatic target_e decodeTarget(input logic [25:0] phys, input logic fetch, input logic write);
		target_e sel;
		sel = TGT_ERR;
		if (phys <= `ROM_WIN_END) begin
			if (write && !fetch) sel = TGT_EXT;
			else if (phys < ROM_LIMIT) sel = TGT_ROM;
			else sel = TGT_ERR;
		end else if (phys <= `EXT_END) begin
			sel = TGT_EXT;
		end else if (phys <= `UNUSABLE_END) begin
			sel = TGT_ERR;
		end else if (phys < `PER_BASE) begin
			sel = (phys >= RAM_START) ? TGT_RAM : TGT_ERR;
		end else begin
			sel = fetch ? TGT_ERR : TGT_PER;
		end
		return sel;
	endfunction : decodeTarget

	// ----------------------------------------
	// Mode pin capture
	// ----------------------------------------
	logic syncA1_reg, syncA2_reg, syncB1_reg, syncB2_reg;
	logic [1:0] captureCnt_reg;
	mode_e opMode_reg;
	logic modeValid_reg;
	mode_e modeDecoded;
	wire captureNow = !modeValid_reg && (captureCnt_reg == `MODE_CAPTURE_CYCLES);

	assign modeDecoded = !syncA2_reg ? MODE_NORMAL :
		(!syncB2_reg ? MODE_FLASHPROG : MODE_PROHIBITED);

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			syncA1_reg <= 1'b0;
			syncA2_reg <= 1'b0;
			syncB1_reg <= 1'b0;
			syncB2_reg <= 1'b0;
		end else begin
			syncA1_reg <= modeSelPinA;
			syncA2_reg <= syncA1_reg;
			syncB1_reg <= modeSelPinB;
			syncB2_reg <= syncB1_reg;
		end
	end

	// Pin A level is held by the programmer or board across release
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			captureCnt_reg <= 2'h0;
			opMode_reg <= MODE_UNSET;
			modeValid_reg <= 1'b0;
		end else if (captureNow) begin
			opMode_reg <= modeDecoded;
			modeValid_reg <= 1'b1;
		end else if (!modeValid_reg) begin
			captureCnt_reg <= captureCnt_reg + 2'h1;
		end
	end

	assign opMode = opMode_reg;
	assign modeValid = modeValid_reg;

	// ----------------------------------------
	// Program counter and fetch
	// ----------------------------------------
	logic [31:0] pc_reg, pc_next;
	logic [25:0] branchSum, stepSum, prefetchPhys;
	target_e prefetchSel;

	assign branchSum = pc_reg[25:0] + branchDisp[25:0];
	assign stepSum = pc_reg[25:0] + {23'h000000, pcStep};
	assign pc_next = pcLoad ? {6'h00, pcLoadAddr[25:0]} :
		pcBranch ? {6'h00, branchSum} :
		pcAdvance ? {6'h00, stepSum} : pc_reg;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) pc_reg <= `PC_RESET;
		else pc_reg <= pc_next;
	end

	assign fetchAddr = pc_reg;
	assign fetchSel = decodeTarget(pc_reg[25:0], 1'b1, 1'b0);
	assign fetchErr = fetchReq && (fetchSel == TGT_ERR);

	// Prefetch stops at the RAM ceiling instead of touching registers
	assign prefetchPhys = pc_reg[25:0] + `PREFETCH_STEP;
	assign prefetchSel = decodeTarget(prefetchPhys, 1'b1, 1'b0);
	assign prefetchAddr = {6'h00, prefetchPhys};
	assign prefetchIssue = prefetchReq && (prefetchPhys < `PER_BASE) && (prefetchSel != TGT_ERR);

	// ----------------------------------------
	// Operand address and request capture
	// ----------------------------------------
	logic [31:0] opSum;
	logic [25:0] dataPhys;
	target_e reqSel;
	logic reqValid_reg, reqWrite_reg;
	size_e reqSize_reg;
	target_e reqSel_reg;
	logic [25:0] reqPhys_reg;
	logic [31:0] reqWdata_reg, reqView_reg;
	logic perBusy, perDone;
	logic [31:0] perRdataWord;
	wire dataTaken = dataReq && dataReady;

	assign opSum = opBase + opDisp;
	assign dataPhys = opSum[25:0];
	assign reqSel = decodeTarget(dataPhys, 1'b0, dataWrite);
	assign dataReady = !reqValid_reg && !perBusy;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			reqValid_reg <= 1'b0;
			reqWrite_reg <= 1'b0;
			reqSize_reg <= SIZE_BYTE;
			reqSel_reg <= TGT_NONE;
			reqPhys_reg <= 26'h0000000;
			reqWdata_reg <= 32'h00000000;
			reqView_reg <= 32'h00000000;
		end else begin
			reqValid_reg <= dataTaken;
			if (dataTaken) begin
				reqWrite_reg <= dataWrite;
				reqSize_reg <= dataSize;
				reqSel_reg <= reqSel;
				reqPhys_reg <= dataPhys;
				reqWdata_reg <= dataWdata;
				reqView_reg <= {{6{dataPhys[25]}}, dataPhys};
			end
		end
	end

	assign dataView = reqView_reg;
	assign dataSel = reqSel_reg;

	// ----------------------------------------
	// Target strobes
	// ----------------------------------------
	wire issueNow = reqValid_reg;
	assign romStrobe = issueNow && (reqSel_reg == TGT_ROM);
	assign ramStrobe = issueNow && (reqSel_reg == TGT_RAM);
	assign extStrobe = issueNow && (reqSel_reg == TGT_EXT);
	assign memWrite = reqWrite_reg;
	assign memSize = reqSize_reg;
	assign memAddr = reqPhys_reg;
	assign memWdata = reqWdata_reg;

	periph_access_splitter u_splitter (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.start(issueNow && (reqSel_reg == TGT_PER)),
		.addr(reqPhys_reg[11:0]),
		.size(reqSize_reg),
		.isWrite(reqWrite_reg),
		.wdata(reqWdata_reg),
		.byteWide(perByteWide),
		.perRdata(perRdata),
		.perStrobe(perStrobe),
		.perAddr(perAddr),
		.perWe(perWe),
		.perByteEn(perByteEn),
		.perWdata(perWdata),
		.busy(perBusy),
		.done(perDone),
		.rdata(perRdataWord)
	);

	// ----------------------------------------
	// Response
	// ----------------------------------------
	logic respValid_reg, accessErr_reg;
	logic [31:0] rdata_reg, memRead;

	assign memRead = (reqSel_reg == TGT_ROM) ? romRdata :
		(reqSel_reg == TGT_RAM) ? ramRdata :
		(reqSel_reg == TGT_EXT) ? extRdata : 32'h00000000;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			respValid_reg <= 1'b0;
			accessErr_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
		end else begin
			respValid_reg <= (issueNow && reqSel_reg != TGT_PER) || perDone;
			accessErr_reg <= issueNow && (reqSel_reg == TGT_ERR);
			if (perDone) rdata_reg <= reqWrite_reg ? 32'h00000000 : perRdataWord;
			else if (issueNow && reqSel_reg != TGT_PER) rdata_reg <= reqWrite_reg ? 32'h00000000 : memRead;
		end
	end

	assign dataRespValid = respValid_reg;
	assign dataRdata = rdata_reg;
	assign accessErr = accessErr_reg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_mode_select: assert property (@(posedge clk_sys) disable iff (!rstn)
		$rose(modeValid) |-> opMode == (!$past(syncA2_reg) ? MODE_NORMAL :
			(!$past(syncB2_reg) ? MODE_FLASHPROG : MODE_PROHIBITED)))
		else $error("mode decoded wrongly at capture");

	chk_mode_stable: assert property (@(posedge clk_sys) disable iff (!rstn)
		modeValid |=> modeValid && $stable(opMode))
		else $error("mode changed after capture");

	chk_pc_upper_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
		pc_reg[31:26] == 6'h00)
		else $error("program counter upper bits not zero");

	chk_pc_branch_wrap: assert property (@(posedge clk_sys) disable iff (!rstn)
		(pcBranch && !pcLoad) |=> pc_reg[25:0] == 26'($past(pc_reg[25:0]) + $past(branchDisp[25:0])))
		else $error("branch target did not wrap in 26 bits");

	chk_data_view: assert property (@(posedge clk_sys) disable iff (!rstn)
		dataTaken |=> dataView[25:0] == 26'($past(opBase) + $past(opDisp)) && dataView[31:26] == {6{dataView[25]}})
		else $error("operand view not folded and sign extended");

	chk_rom_write_ext: assert property (@(posedge clk_sys) disable iff (!rstn)
		(dataTaken && dataWrite && dataPhys <= `ROM_WIN_END) |=> extStrobe && !romStrobe)
		else $error("write to lowest megabyte not sent external");

	chk_rom_size: assert property (@(posedge clk_sys) disable iff (!rstn)
		(fetchReq && pc_reg[25:0] <= `ROM_WIN_END) |-> (fetchErr == (pc_reg[25:0] >= ROM_LIMIT)))
		else $error("rom size boundary decoded wrongly");

	chk_ram_size: assert property (@(posedge clk_sys) disable iff (!rstn)
		(fetchReq && pc_reg[25:0] >= `RAM_WIN_BASE && pc_reg[25:0] < `PER_BASE) |->
			(fetchSel == (pc_reg[25:0] >= RAM_START ? TGT_RAM : TGT_ERR)))
		else $error("ram start boundary decoded wrongly");

	chk_no_per_fetch: assert property (@(posedge clk_sys) disable iff (!rstn)
		(fetchReq && (pc_reg[25:0] >= `PER_BASE || (pc_reg[25:0] > `EXT_END && pc_reg[25:0] <= `UNUSABLE_END)))
			|-> fetchErr)
		else $error("fetch from peripheral or unusable area not refused");

	chk_prefetch_guard: assert property (@(posedge clk_sys) disable iff (!rstn)
		prefetchIssue |-> prefetchPhys < `PER_BASE)
		else $error("prefetch crossed into peripheral area");

	chk_err_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
		(dataTaken && reqSel == TGT_ERR) |=> !romStrobe && !ramStrobe && !extStrobe ##1
			(dataRespValid && accessErr && dataRdata == 32'h00000000))
		else $error("prohibited access not answered with error and zero");
endmodule : cpu_address_map_decoder

/* sim/mem_partner_model.sv */
`timescale 1ns/100ps
module mem_partner_model (
	input wire logic clk_sys,
	input wire logic romStrobe,
	input wire logic ramStrobe,
	input wire logic extStrobe,
	input wire logic [25:0] memAddr,
	input wire logic perStrobe,
	input wire logic [11:0] perAddr,
	output logic [31:0] romRdata,
	output logic [31:0] ramRdata,
	output logic [31:0] extRdata,
	output logic [15:0] perRdata,
	output logic perByteWide
);
	// ----------------------------------------
	// Memories answer from the address; idle buses churn
	// ----------------------------------------
	logic [31:0] idleCnt = 32'h0;
	always_ff @(posedge clk_sys) begin
		idleCnt <= idleCnt + 32'h9E3779B9;
	end
	assign romRdata = romStrobe ? ({6'h00, memAddr} ^ 32'hA5000000) : idleCnt;
	assign ramRdata = ramStrobe ? ({6'h00, memAddr} ^ 32'h5A000000) : ~idleCnt;
	assign extRdata = extStrobe ? ({6'h00, memAddr} ^ 32'h3C000000) : idleCnt;
	assign perRdata = perStrobe ? {4'hC, perAddr} : ~idleCnt[15:0];
	// Upper half of the area holds byte-wide registers
	assign perByteWide = perAddr[11];
endmodule : mem_partner_model

/* sim/cpu_address_map_decoder_tb_top.sv */
`timescale 1ns/100ps
module cpu_address_map_decoder_tb_top;
	import cpu_addr_map_pkg::*;
	logic clk_sys = 1'h0, rstn = 1'h0, modeSelPinA = 1'h0, modeSelPinB = 1'h0;
	logic pcLoad = 1'h0, pcBranch = 1'h0, pcAdvance = 1'h0, fetchReq = 1'h1, prefetchReq = 1'h1;
	logic [31:0] pcLoadAddr = 32'h0, branchDisp = 32'h0, opBase = 32'h0, opDisp = 32'h0;
	logic [2:0] pcStep = 3'h4;
	logic dataReq = 1'h0, dataWrite = 1'h0;
	size_e dataSize = SIZE_WORD;
	logic [31:0] dataWdata = 32'h1234ABCD;
	mode_e opMode;
	target_e fetchSel, dataSel;
	size_e memSize;
	logic modeValid, fetchErr, prefetchIssue, dataReady, romStrobe, ramStrobe, extStrobe, memWrite;
	logic perByteWide, perStrobe, perWe, dataRespValid, accessErr;
	logic [31:0] fetchAddr, prefetchAddr, dataView, memWdata, romRdata, ramRdata, extRdata, dataRdata;
	logic [25:0] memAddr;
	logic [15:0] perRdata, perWdata, lastWd;
	logic [11:0] perAddr;
	logic [1:0] perByteEn, lastEn;
	logic [11:0] perQ[$];
	integer failures = 0;
	integer compares = 0;
	integer seed = 85179;
	logic [31:0] r, d;
	logic [25:0] t;

	always #50 clk_sys = ~clk_sys;

	cpu_address_map_decoder cpu_address_map_decoder_inst (
		.clk_sys, .rstn, .modeSelPinA, .modeSelPinB, .opMode, .modeValid, .pcLoad, .pcLoadAddr,
		.pcBranch, .branchDisp, .pcAdvance, .pcStep, .fetchReq, .fetchAddr, .fetchSel, .fetchErr,
		.prefetchReq, .prefetchAddr, .prefetchIssue, .dataReq, .dataWrite, .dataSize, .opBase,
		.opDisp, .dataWdata, .dataReady, .dataView, .dataSel, .romStrobe, .ramStrobe, .extStrobe,
		.memWrite, .memSize, .memAddr, .memWdata, .romRdata, .ramRdata, .extRdata, .perByteWide,
		.perRdata, .perStrobe, .perAddr, .perWe, .perByteEn, .perWdata, .dataRespValid,
		.dataRdata, .accessErr
	);
	mem_partner_model mem_partner_model_inst (
		.clk_sys, .romStrobe, .ramStrobe, .extStrobe, .memAddr, .perStrobe, .perAddr,
		.romRdata, .ramRdata, .extRdata, .perRdata, .perByteWide
	);

	// ----------------------------------------
	// Reporting
	// ----------------------------------------
	task automatic print_verdict;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares = compares + 1;
		if (g !== e) begin
			failures = failures + 1;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk

	// ----------------------------------------
	// Drivers
	// ----------------------------------------
	task automatic doReset(input logic a, input logic b);
		rstn = 1'h0;
		modeSelPinA = a;
		modeSelPinB = b;
		repeat (8) @(posedge clk_sys);
		#10 rstn = 1'h1;
	endtask : doReset

	task automatic pcOp(input logic [1:0] kind, input logic [31:0] val);
		pcLoad = (kind == 2'h0);
		pcBranch = (kind == 2'h1);
		pcAdvance = (kind == 2'h2);
		pcLoadAddr = val;
		branchDisp = val;
		@(posedge clk_sys);
		#10;
		pcLoad = 1'h0;
		pcBranch = 1'h0;
		pcAdvance = 1'h0;
		@(posedge clk_sys);
		#10;
	endtask : pcOp

	// Random upper bits and a random split of the sum exercise both wraps
	task automatic acc(input logic [25:0] ph, input logic wr, input size_e sz, input target_e es,
			input logic [31:0] ed, input logic [31:0] mask);
		int n;
		int strobes;
		logic [2:0] ev;
		ev = {es == TGT_ROM, es == TGT_RAM, es == TGT_EXT};
		r = $random(seed);
		opBase = $random(seed);
		opDisp = {r[5:0], ph} - opBase;
		dataReq = 1'h1;
		dataWrite = wr;
		dataSize = sz;
		n = 0;
		while (dataReady !== 1'h1 && n < 20) begin
			@(posedge clk_sys);
			#10 n++;
		end
		if (dataReady !== 1'h1) begin
			failures = failures + 1;
			$display("[ERR] %0t never ready", $time);
			print_verdict();
		end
		@(posedge clk_sys);
		#10 dataReq = 1'h0;
		strobes = 0;
		perQ.delete();
		n = 0;
		while (dataRespValid !== 1'h1 && n < 10) begin
			if ((romStrobe | ramStrobe | extStrobe) === 1'h1) begin
				strobes++;
				chk({romStrobe, ramStrobe, extStrobe}, ev);
				chk({6'h00, memAddr}, {6'h00, ph});
				chk(memWrite, wr);
				chk(memSize, sz);
				chk(memWdata, dataWdata);
			end
			if (perStrobe === 1'h1) begin
				perQ.push_back(perAddr);
				chk(perWe, wr);
				lastEn = perByteEn;
				lastWd = perWdata;
			end
			@(posedge clk_sys);
			#10 n++;
		end
		if (dataRespValid !== 1'h1) begin
			failures = failures + 1;
			$display("[ERR] %0t no response", $time);
			print_verdict();
		end
		chk(dataSel, es);
		chk(dataView, {{6{ph[25]}}, ph});
		chk(accessErr, es == TGT_ERR);
		chk(dataRdata & mask, ed);
		chk(strobes, ev != 3'h0);
	endtask : acc

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	logic [31:0] fA[9] = '{32'hFC000100, 32'h0009FFFC, 32'h000A0000, 32'h00100000, 32'h01000000,
		32'h03FEFFFC, 32'h03FF2FFC, 32'h03FF3000, 32'h03FFF000};
	target_e fS[9] = '{TGT_ROM, TGT_ROM, TGT_ERR, TGT_EXT, TGT_ERR, TGT_ERR, TGT_ERR, TGT_RAM, TGT_ERR};

	initial begin
		for (int i = 3; i >= 0; i--) begin
			doReset(i[1], i[0]);
			chk(modeValid, 1'h0);
			repeat (6) @(posedge clk_sys);
			#10;
			chk(opMode, i[1] ? (i[0] ? MODE_PROHIBITED : MODE_FLASHPROG) : MODE_NORMAL);
			chk(modeValid, 1'h1);
		end
		for (int i = 0; i < 9; i++) begin
			pcOp(2'h0, fA[i]);
			chk(fetchAddr, {6'h00, fA[i][25:0]});
			chk(fetchSel, fS[i]);
			chk(fetchErr, fS[i] == TGT_ERR);
		end
		fetchReq = 1'h0;
		pcOp(2'h2, 32'h0);
		chk(fetchErr, 1'h0);
		fetchReq = 1'h1;
		pcOp(2'h0, 32'h03FFFFFC);
		chk(prefetchAddr, 32'h0);
		pcOp(2'h2, 32'h0);
		chk(fetchAddr, 32'h0);
		pcOp(2'h0, 32'h00000010);
		pcOp(2'h1, 32'hFFFFEFE0);
		chk(fetchAddr, 32'h03FFEFF0);
		chk(fetchSel, TGT_RAM);
		for (int i = 0; i < 4; i++) begin
			r = $random(seed) & 32'hFFFFEFFF;
			d = $random(seed);
			t = r[25:0] + d[25:0];
			if (&t[25:12]) d = d - 32'h1000;
			pcOp(2'h0, r);
			pcOp(2'h1, d);
			t = r[25:0] + d[25:0];
			chk(fetchAddr, {6'h00, t});
		end
		pcOp(2'h0, 32'h03FFEFFC);
		chk(prefetchIssue, 1'h0);
		pcOp(2'h0, 32'h03FFEFF8);
		chk(prefetchIssue, 1'h1);
		chk(prefetchAddr, 32'h03FFEFFC);
		acc(26'h0000010, 1'h0, SIZE_WORD, TGT_ROM, 32'hA5000010, 32'hFFFFFFFF);
		acc(26'h0000020, 1'h1, SIZE_WORD, TGT_EXT, 32'h0, 32'hFFFFFFFF);
		acc(26'h00A0000, 1'h0, SIZE_WORD, TGT_ERR, 32'h0, 32'hFFFFFFFF);
		acc(26'h00A0000, 1'h1, SIZE_WORD, TGT_EXT, 32'h0, 32'hFFFFFFFF);
		acc(26'h3FF3000, 1'h0, SIZE_WORD, TGT_RAM, 32'h59FF3000, 32'hFFFFFFFF);
		acc(26'h3FFEFFC, 1'h0, SIZE_WORD, TGT_RAM, 32'h59FFEFFC, 32'hFFFFFFFF);
		acc(26'h3FF2FFC, 1'h0, SIZE_WORD, TGT_ERR, 32'h0, 32'hFFFFFFFF);
		acc(26'h0100000, 1'h0, SIZE_WORD, TGT_EXT, 32'h3C100000, 32'hFFFFFFFF);
		acc(26'h0FFFFFC, 1'h0, SIZE_WORD, TGT_EXT, 32'h3CFFFFFC, 32'hFFFFFFFF);
		acc(26'h1000000, 1'h0, SIZE_WORD, TGT_ERR, 32'h0, 32'hFFFFFFFF);
		acc(26'h3FEFFFC, 1'h1, SIZE_WORD, TGT_ERR, 32'h0, 32'hFFFFFFFF);
		for (int i = 0; i < 4; i++) begin
			r = $random(seed);
			acc({7'h00, r[18:2], 2'h0}, 1'h0, SIZE_WORD, TGT_ROM, 32'hA5000000 ^ {13'h0, r[18:2], 2'h0},
				32'hFFFFFFFF);
		end
		acc(26'h3FFF107, 1'h0, SIZE_WORD, TGT_PER, 32'hC106C104, 32'hFFFFFFFF);
		chk(perQ.size(), 2);
		chk({perQ[0], perQ[1]}, {12'h104, 12'h106});
		acc(26'h3FFF805, 1'h0, SIZE_HALF, TGT_PER, 32'h0000C804, 32'h0000FFFF);
		acc(26'h3FFF809, 1'h0, SIZE_BYTE, TGT_PER, 32'h000000C8, 32'hFFFFFFFF);
		acc(26'h3FFF806, 1'h1, SIZE_HALF, TGT_PER, 32'h0, 32'hFFFFFFFF);
		chk({lastEn, lastWd[7:0]}, {2'h1, 8'hCD});
		print_verdict();
	end
endmodule : cpu_address_map_decoder_tb_top
